//--- hw/its_pkg.sv
// Constants and carriers for the interleaved time-of-flight sequencer.
// Assumes a single 200 MHz system clock; all times below are converted to its cycles.
package its_pkg;

  // System clock
  localparam int unsigned CLK_PERIOD_PS     = 5000;

  // Direct counting mode limits
  localparam int unsigned MODE1_MIN_NS      = 12;
  localparam int unsigned MODE1_MIN_CYC     = (MODE1_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                              / CLK_PERIOD_PS;
  localparam int unsigned MODE1_REC_MAX_NS  = 500;
  localparam int unsigned MODE1_REC_MAX_CYC = (MODE1_REC_MAX_NS * 1000) / CLK_PERIOD_PS;

  // Reference-clock counting mode limits
  localparam int unsigned REF_MAX_KHZ       = 16000;
  localparam int unsigned REF_MIN_PER_PS    = 1000000000 / REF_MAX_KHZ;
  localparam int unsigned REF_MIN_PER_CYC   = REF_MIN_PER_PS / CLK_PERIOD_PS;
  localparam int unsigned MODE2_MIN_NS      = 125;
  localparam int unsigned MODE2_MIN_CYC     = (MODE2_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                              / CLK_PERIOD_PS;
  localparam int unsigned MODE2_MIN_REF     = 2;

  // Widths and reset values
  localparam int unsigned CNT_W             = 16;
  localparam logic [15:0] CNT_RST           = 16'h0000;
  localparam int unsigned SYNC_W            = 4;
  localparam logic [3:0]  SYNC_RST          = 4'h0;

  // Counting modes
  typedef enum logic [0:0] {
    ITS_MODE_DIRECT = 1'b0,
    ITS_MODE_REFCLK = 1'b1
  } its_mode_e;

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ITS_IDLE  = 6'b00_0001,
    ITS_ARMED = 6'b00_0010,
    ITS_DIRCT = 6'b00_0100,
    ITS_FRAC1 = 6'b00_1000,
    ITS_REFCT = 6'b01_0000,
    ITS_FRAC2 = 6'b10_0000
  } its_state_e;

  // Pin group entering the switch, bit order fixed for the synchroniser
  typedef struct packed {
    logic ref_clk;
    logic ref_pulse;
    logic external_stop_edge;
    logic external_start_edge;
  } its_pins_s;

  // Measurement result
  typedef struct packed {
    its_mode_e        mode;
    logic [CNT_W-1:0] frac_start;
    logic [CNT_W-1:0] ref_cycles;
    logic [CNT_W-1:0] frac_stop;
    logic             too_short;
    logic             over_range;
    logic             ref_too_fast;
  } its_result_s;

endpackage

//--- hw/its_tof_seq.sv
// Converter-side sequencer: input switch plus stopwatch in two counting modes.
// Assumes pins are asynchronous to clk and controls come from logic on clk.
// Fine time is measured in clk cycles; the fraction counters stand in for the ring oscillator.

module its_tof_seq (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // Asynchronous pins into the switch
  input  wire its_pkg::its_pins_s   pins,
  // Controls from the controller
  input  wire logic                 route_sel_a,
  input  wire logic                 route_sel_b,
  input  wire its_pkg::its_mode_e   mode,
  input  wire logic                 meas_go,
  // Status and result
  output logic                      busy_ff,
  output logic                      result_valid_ff,
  output its_pkg::its_result_s      result_ff
);

  // Two-stage synchroniser per pin, plus one history stage for edge detection
  logic [its_pkg::SYNC_W-1:0] sync2_ff;
  logic [its_pkg::SYNC_W-1:0] prev_ff;

  genvar gi;
  generate
    for (gi = 0; gi < its_pkg::SYNC_W; gi++) begin : g_sync
      // Per-bit flops so each vector bit has a single writer
      logic s1_ff;
      logic s2_ff;
      logic p_ff;
      always_ff @(posedge clk) begin
        if (!nrst) begin
          s1_ff <= its_pkg::SYNC_RST[gi];
          s2_ff <= its_pkg::SYNC_RST[gi];
          p_ff  <= its_pkg::SYNC_RST[gi];
        end else begin
          s1_ff <= pins[gi];
          s2_ff <= s1_ff;
          p_ff  <= s2_ff;
        end
      end
      assign sync2_ff[gi] = s2_ff;
      assign prev_ff[gi]  = p_ff;
    end
  endgenerate

  its_pkg::its_pins_s pin_s;
  its_pkg::its_pins_s pin_p;
  assign pin_s = its_pkg::its_pins_s'(sync2_ff);
  assign pin_p = its_pkg::its_pins_s'(prev_ff);

  // Input switch; the unused select pair falls back to straight-through
  logic conv_start;
  logic conv_stop;
  always_comb begin
    conv_start = pin_s.external_start_edge;
    conv_stop  = pin_s.external_stop_edge;
    if (route_sel_a && route_sel_b) begin
      conv_start = pin_s.ref_pulse;
      conv_stop  = pin_s.external_start_edge;
    end else if (route_sel_a) begin
      conv_start = pin_s.ref_pulse;
      conv_stop  = pin_s.external_stop_edge;
    end
  end

  // Previous routed levels, same selection on the delayed copies
  logic conv_start_p;
  logic conv_stop_p;
  always_comb begin
    conv_start_p = pin_p.external_start_edge;
    conv_stop_p  = pin_p.external_stop_edge;
    if (route_sel_a && route_sel_b) begin
      conv_start_p = pin_p.ref_pulse;
      conv_stop_p  = pin_p.external_start_edge;
    end else if (route_sel_a) begin
      conv_start_p = pin_p.ref_pulse;
      conv_stop_p  = pin_p.external_stop_edge;
    end
  end

  logic start_rise;
  logic stop_rise;
  logic ref_rise;
  assign start_rise = conv_start && !conv_start_p;
  assign stop_rise  = conv_stop && !conv_stop_p;
  assign ref_rise   = pin_s.ref_clk && !pin_p.ref_clk;

  // Sequencer state
  its_pkg::its_state_e          state_ff;
  its_pkg::its_state_e          nxt_state;
  its_pkg::its_mode_e           mode_ff;
  its_pkg::its_mode_e           nxt_mode;
  logic [its_pkg::CNT_W-1:0]    fine_ff;
  logic [its_pkg::CNT_W-1:0]    nxt_fine;
  logic [its_pkg::CNT_W-1:0]    coarse_ff;
  logic [its_pkg::CNT_W-1:0]    nxt_coarse;
  logic [its_pkg::CNT_W-1:0]    total_ff;
  logic [its_pkg::CNT_W-1:0]    nxt_total;
  logic [its_pkg::CNT_W-1:0]    refper_ff;
  logic [its_pkg::CNT_W-1:0]    nxt_refper;
  // Start fraction parked here so result_ff only moves with valid
  logic [its_pkg::CNT_W-1:0]    frac1_ff;
  logic [its_pkg::CNT_W-1:0]    nxt_frac1;
  logic                         fast_ff;
  logic                         nxt_fast;
  logic                         busy_nxt;
  logic                         nxt_valid;
  its_pkg::its_result_s         nxt_result;

  // Saturating increment so a missing stop cannot wrap a count
  function automatic logic [its_pkg::CNT_W-1:0] sat_inc(input logic [its_pkg::CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + its_pkg::CNT_W'(1);
  endfunction

  always_comb begin
    nxt_state  = state_ff;
    nxt_mode   = mode_ff;
    nxt_fine   = fine_ff;
    nxt_coarse = coarse_ff;
    nxt_total  = total_ff;
    nxt_refper = refper_ff;
    nxt_frac1  = frac1_ff;
    nxt_fast   = fast_ff;
    nxt_valid  = 1'b0;
    nxt_result = result_ff;
    busy_nxt   = busy_ff;

    case (state_ff)
      its_pkg::ITS_IDLE: begin
        if (meas_go) begin
          nxt_state  = its_pkg::ITS_ARMED;
          nxt_mode   = mode;
          nxt_fine   = its_pkg::CNT_RST;
          nxt_coarse = its_pkg::CNT_RST;
          nxt_total  = its_pkg::CNT_RST;
          nxt_refper = its_pkg::CNT_RST;
          nxt_fast   = 1'b0;
          busy_nxt   = 1'b1;
        end
      end
      its_pkg::ITS_ARMED: begin
        if (start_rise) begin
          nxt_state = (mode_ff == its_pkg::ITS_MODE_DIRECT) ? its_pkg::ITS_DIRCT
                                                            : its_pkg::ITS_FRAC1;
          nxt_fine  = its_pkg::CNT_W'(1);
          nxt_total = its_pkg::CNT_W'(1);
        end
      end
      its_pkg::ITS_DIRCT: begin
        // Fine count in low part, coarse count on its overflow
        if (stop_rise) begin
          nxt_result.mode         = its_pkg::ITS_MODE_DIRECT;
          nxt_result.frac_start   = fine_ff;
          nxt_result.ref_cycles   = coarse_ff;
          nxt_result.frac_stop    = its_pkg::CNT_RST;
          nxt_result.too_short    = total_ff < its_pkg::CNT_W'(its_pkg::MODE1_MIN_CYC);
          nxt_result.over_range   = total_ff > its_pkg::CNT_W'(its_pkg::MODE1_REC_MAX_CYC);
          nxt_result.ref_too_fast = 1'b0;
          nxt_valid               = 1'b1;
          busy_nxt                = 1'b0;
          nxt_state               = its_pkg::ITS_IDLE;
        end else begin
          nxt_total = sat_inc(total_ff);
          nxt_fine  = (&fine_ff) ? its_pkg::CNT_RST : fine_ff + its_pkg::CNT_W'(1);
          if (&fine_ff) begin
            nxt_coarse = sat_inc(coarse_ff);
          end
        end
      end
      its_pkg::ITS_FRAC1: begin
        nxt_total = sat_inc(total_ff);
        if (stop_rise) begin
          // Stop before the first reference edge would otherwise hang the count
          nxt_state = its_pkg::ITS_FRAC2;
          nxt_frac1 = fine_ff;
          nxt_fine  = its_pkg::CNT_W'(1);
        end else if (ref_rise) begin
          nxt_state  = its_pkg::ITS_REFCT;
          nxt_refper = its_pkg::CNT_RST;
        end else begin
          nxt_fine = sat_inc(fine_ff);
        end
      end
      its_pkg::ITS_REFCT: begin
        nxt_total  = sat_inc(total_ff);
        nxt_refper = sat_inc(refper_ff);
        if (ref_rise) begin
          nxt_coarse = sat_inc(coarse_ff);
          nxt_refper = its_pkg::CNT_RST;
          if (refper_ff < its_pkg::CNT_W'(its_pkg::REF_MIN_PER_CYC - 1)) begin
            nxt_fast = 1'b1;
          end
        end
        if (stop_rise) begin
          nxt_state  = its_pkg::ITS_FRAC2;
          nxt_coarse = coarse_ff;
          nxt_frac1  = fine_ff;
          nxt_fine   = its_pkg::CNT_W'(1);
        end
      end
      its_pkg::ITS_FRAC2: begin
        nxt_total = sat_inc(total_ff);
        if (ref_rise) begin
          nxt_result.mode         = its_pkg::ITS_MODE_REFCLK;
          nxt_result.frac_start   = frac1_ff;
          nxt_result.ref_cycles   = coarse_ff;
          nxt_result.frac_stop    = fine_ff;
          // Span check stands in for the controller's own choice of mode
          nxt_result.too_short    = (coarse_ff < its_pkg::CNT_W'(its_pkg::MODE2_MIN_REF))
                                 || (total_ff < its_pkg::CNT_W'(its_pkg::MODE2_MIN_CYC));
          nxt_result.over_range   = 1'b0;
          nxt_result.ref_too_fast = fast_ff;
          nxt_valid               = 1'b1;
          busy_nxt                = 1'b0;
          nxt_state               = its_pkg::ITS_IDLE;
        end else begin
          nxt_fine = sat_inc(fine_ff);
        end
      end
      default: begin
        nxt_state = its_pkg::ITS_IDLE;
        busy_nxt  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff        <= its_pkg::ITS_IDLE;
      mode_ff         <= its_pkg::ITS_MODE_DIRECT;
      fine_ff         <= its_pkg::CNT_RST;
      coarse_ff       <= its_pkg::CNT_RST;
      total_ff        <= its_pkg::CNT_RST;
      refper_ff       <= its_pkg::CNT_RST;
      frac1_ff        <= its_pkg::CNT_RST;
      fast_ff         <= 1'b0;
      busy_ff         <= 1'b0;
      result_valid_ff <= 1'b0;
      result_ff       <= '0;
    end else begin
      state_ff        <= nxt_state;
      mode_ff         <= nxt_mode;
      fine_ff         <= nxt_fine;
      coarse_ff       <= nxt_coarse;
      total_ff        <= nxt_total;
      refper_ff       <= nxt_refper;
      frac1_ff        <= nxt_frac1;
      fast_ff         <= nxt_fast;
      busy_ff         <= busy_nxt;
      result_valid_ff <= nxt_valid;
      result_ff       <= nxt_result;
    end
  end

endmodule

//--- bench/its_tof_seq_asserts.sv
// Checker on the sequencer's control and result ports.
// Assumes one clock domain with synchronous active-low reset.
module its_chk (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 nrst,
  // Inputs
  input wire its_pkg::its_pins_s   pins,
  input wire logic                 route_sel_a,
  input wire logic                 route_sel_b,
  input wire its_pkg::its_mode_e   mode,
  input wire logic                 meas_go,
  // Outputs
  input wire logic                 busy_ff,
  input wire logic                 result_valid_ff,
  input wire its_pkg::its_result_s result_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  its_pkg::its_mode_e mode_ff;
  its_pkg::its_mode_e nxt_mode;
  logic               dir_res;
  // Mode captured at an accepted start, compared at result time
  assign nxt_mode = (meas_go && !busy_ff) ? mode : mode_ff;
  always_ff @(posedge clk) begin
    mode_ff <= nxt_mode;
  end
  assign dir_res = result_valid_ff && result_ff.mode == its_pkg::ITS_MODE_DIRECT
                   && result_ff.ref_cycles == 16'h0000;
  reset_clear_a: assert property (disable iff (1'b0) !nrst |=> !busy_ff
    && !result_valid_ff && result_ff == '0) else $error("reset left outputs set");
  go_busy_a: assert property (meas_go && !busy_ff |=> busy_ff)
    else $error("accepted start did not raise busy");
  busy_cause_a: assert property ($rose(busy_ff) |-> $past(meas_go))
    else $error("busy rose without start");
  valid_pulse_a: assert property (result_valid_ff |=> !result_valid_ff)
    else $error("result valid longer than one cycle");
  valid_busy_a: assert property (result_valid_ff |-> !busy_ff && $past(busy_ff))
    else $error("result not at end of busy");
  result_hold_a: assert property (!result_valid_ff && $past(nrst) |-> $stable(result_ff))
    else $error("result changed without valid");
  short_flag_a: assert property (dir_res |-> result_ff.too_short
    == (result_ff.frac_start < its_pkg::MODE1_MIN_CYC)) else $error("short flag wrong");
  range_flag_a: assert property (dir_res |-> result_ff.over_range
    == (result_ff.frac_start > its_pkg::MODE1_REC_MAX_CYC)) else $error("range flag wrong");
  mode_keep_a: assert property (result_valid_ff |-> result_ff.mode == mode_ff)
    else $error("result mode differs from request");
  cover property (dir_res && result_ff.too_short);
  cover property (result_valid_ff && result_ff.mode == its_pkg::ITS_MODE_REFCLK);
  cover property (route_sel_a && route_sel_b && result_valid_ff);
endmodule

bind its_tof_seq its_chk i_its_chk (.clk, .nrst, .pins, .route_sel_a, .route_sel_b,
  .mode, .meas_go, .busy_ff, .result_valid_ff, .result_ff);

//--- bench/its_pulse_src.sv
// Model of the pulse generator and reference oscillator feeding the switch.
// Assumes lines change 1 ns after the rising clk edge, as the bench does.
module its_pulse_src (
  // Clock and trigger
  input  wire logic         clk,
  input  wire logic         fire,
  // Edge delays and reference period, in clk cycles
  input  wire logic [8:0]   d_start,
  input  wire logic [8:0]   d_stop,
  input  wire logic [7:0]   ref_per,
  // Lines into the switch
  output its_pkg::its_pins_s pins
);
  timeunit 1ns;
  timeprecision 100ps;
  int   t = 1000;
  int   r = 0;
  logic f;
  initial pins = '0;
  // Oscillator runs free; pulses are 8 cycles wide so every edge is fresh
  always @(posedge clk) begin
    f = fire;
    #1;
    t = f ? 0 : t + 1;
    r = (r + 1 >= int'(ref_per)) ? 0 : r + 1;
    pins.ref_clk = r < int'(ref_per) / 2;
    pins.ref_pulse = t < 8;
    pins.external_start_edge = t >= int'(d_start) && t < int'(d_start) + 8;
    pins.external_stop_edge = t >= int'(d_stop) && t < int'(d_stop) + 8;
  end
endmodule

//--- bench/testbench.sv
// Bench: direct, interleaved and reference-clock measurements.
// Assumes the pulse source model and the bound checker.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                 clk = 1'b0;
  logic                 nrst = 1'b0;
  logic                 go = 1'b0;
  logic                 fire = 1'b0;
  logic                 sa = 1'b0;
  logic                 sb = 1'b0;
  its_pkg::its_mode_e   md = its_pkg::ITS_MODE_DIRECT;
  logic [8:0]           ds = 9'h000;
  logic [8:0]           dp = 9'h000;
  logic [7:0]           rp = 8'h0d;
  its_pkg::its_pins_s   pins;
  logic                 busy_ff;
  logic                 result_valid_ff;
  its_pkg::its_result_s result_ff;
  int                   n_errors = 0;
  int                   checked = 0;
  int                   dl[5] = '{2, 3, 40, 100, 101};
  int                   il[3] = '{12, 9, 10};
  logic [15:0]          r1;
  realtime              t0;
  localparam its_pkg::its_mode_e DIR = its_pkg::ITS_MODE_DIRECT;
  localparam its_pkg::its_mode_e REF = its_pkg::ITS_MODE_REFCLK;

  always #2.5 clk = ~clk;

  its_tof_seq i_its_tof_seq (.clk, .nrst, .pins, .route_sel_a(sa), .route_sel_b(sb),
    .mode(md), .meas_go(go), .busy_ff, .result_valid_ff, .result_ff);
  its_pulse_src i_its_pulse_src (.clk, .fire, .d_start(ds), .d_stop(dp), .ref_per(rp),
    .pins);

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Selects settle before arming and stay put until the next call
  task automatic meas(logic a, logic b, its_pkg::its_mode_e m, int s, int p);
    int k;
    sa = a;
    sb = b;
    md = m;
    ds = 9'(s);
    dp = 9'(p);
    go = 1'b1;
    @(posedge clk) #1;
    go = 1'b0;
    fire = 1'b1;
    @(posedge clk) #1;
    fire = 1'b0;
    for (k = 0; k < 3000 && result_valid_ff !== 1'b1; k++) @(posedge clk) #1;
    if (k == 3000) begin
      n_errors++;
      conclude();
    end
  endtask

  initial begin
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    chk("busy", 16'h0000, 16'(busy_ff));
    foreach (dl[i]) begin
      meas(1'b0, 1'b0, DIR, 10, 10 + dl[i]);
      chk("dir_time", 16'(dl[i]), result_ff.frac_start);
      chk("flags", 16'({dl[i] < 3, dl[i] > 100}),
          16'({result_ff.too_short, result_ff.over_range}));
    end
    $display("test direct done");
    foreach (il[i]) begin
      t0 = $realtime;
      meas(1'b1, 1'b1, DIR, 10, il[i]);
      r1 = result_ff.frac_start;
      chk("ref_to_start", 16'h000a, r1);
      meas(1'b1, 1'b0, DIR, 10, il[i]);
      chk("difference", 16'(il[i] - 10), result_ff.frac_start - r1);
      chk("window", 16'h0001, 16'($realtime - t0 <= 10000.0));
    end
    $display("test interleaved done");
    meas(1'b0, 1'b0, REF, 10, 310);
    chk("ref_span", 16'h0001, 16'(result_ff.ref_cycles >= 16'h0016
        && result_ff.ref_cycles <= 16'h0018));
    chk("ref_sum", 16'h012c, result_ff.frac_start - result_ff.frac_stop
        + 16'h000d * (result_ff.ref_cycles + 16'h0001));
    chk("ref_flags", 16'h0000,
        16'({result_ff.too_short, result_ff.ref_too_fast}));
    meas(1'b0, 1'b0, REF, 10, 20);
    chk("ref_short", 16'h0001, 16'(result_ff.too_short));
    rp = 8'h0a;
    meas(1'b0, 1'b0, REF, 10, 200);
    chk("ref_fast", 16'h0001, 16'(result_ff.ref_too_fast));
    $display("test refclk done");
    conclude();
  end
endmodule
